// *** verilog/asc_pkg.sv ***
// Purpose: Shared constants and types for the converter sequencer control block
// Assumes: 8-bit register port, registers at their byte offsets
// Notes:   Types and functions carry the asc_ prefix, state names ASC_; other constants do not
package asc_pkg;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RES_LO  = 8'h78;
  localparam logic [7:0] OFS_RES_HI  = 8'h79;
  localparam logic [7:0] OFS_CTRL    = 8'h7A;
  localparam logic [7:0] OFS_CTRL_B  = 8'h7B;
  localparam logic [7:0] OFS_SEL     = 8'h7C;

  localparam int CS_EN    = 7;
  localparam int CS_START = 6;
  localparam int CS_ATE   = 5;
  localparam int CS_FLAG  = 4;
  localparam int CS_IE    = 3;
  localparam int SEL_LADJ = 5;

  localparam logic [7:0] RST_SEL    = 8'h00;
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [2:0] RST_TRIG   = 3'h0;
  localparam logic [2:0] TRIG_FREE  = 3'h0;

  // ----------------------------------------------------------------
  // Conversion lengths in converter clocks
  // ----------------------------------------------------------------
  localparam logic [4:0] LEN_FIRST  = 5'h19;
  localparam logic [4:0] LEN_NORMAL = 5'h0D;

  localparam logic [9:0] SE_MAX     = 10'h3FF;
  localparam logic [9:0] DIFF_POS   = 10'h1FF;
  localparam logic [9:0] DIFF_NEG   = 10'h200;

  typedef enum logic [0:0] {
    ASC_IDLE = 1'b0,
    ASC_CONV = 1'b1
  } asc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } asc_bus_t;

  typedef struct packed {
    logic       power;
    logic       busy;
    logic [1:0] reference_select;
    logic [4:0] channel_select;
    logic       sample;
  } asc_core_t;

  // Differential codes are 10000..11101; bandgap and ground are single-ended
  function automatic logic asc_is_diff(input logic [4:0] ch);
    asc_is_diff = ch[4] && (ch[4:1] != 4'hF);
  endfunction

endpackage

// *** verilog/asc_clk_div.sv ***
// Purpose: Converter clock prescaler producing one-cycle ticks
// Assumes: run low holds the counter cleared
// Notes:   Tick is registered, one system clock wide
`timescale 1ns/1ps
module asc_clk_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  output logic            tick
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } asc_div_st_t;

  asc_div_st_t cur_ff;
  asc_div_st_t nxt_st;
  logic [6:0]  last;

  always_comb begin
    // Codes 000 and 001 both divide by two
    last = (div_sel == 3'h0) ? 7'h01 : 7'((8'h01 << div_sel) - 8'h01);
    nxt_st = cur_ff;
    nxt_st.tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = 7'h00;
    end else if (cur_ff.cnt >= last) begin
      nxt_st.cnt = 7'h00;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = cur_ff.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_st;
    end
  end

  assign tick = cur_ff.tick;

endmodule

// *** verilog/asc_code_fmt.sv ***
// Purpose: Saturate the raw core code into a 10-bit result
// Assumes: Raw code is a signed count of steps from the core
// Notes:   Purely combinational
`timescale 1ns/1ps
module asc_code_fmt (
  input  wire logic signed [11:0] raw,
  input  wire logic               diff,
  output logic             [9:0]  code
);

  always_comb begin
    if (diff) begin
      if (raw > 12'sh1FF) begin
        code = asc_pkg::DIFF_POS;
      end else if (raw < -12'sh200) begin
        code = asc_pkg::DIFF_NEG;
      end else begin
        code = raw[9:0];
      end
    end else begin
      if (raw < 12'sh000) begin
        code = 10'h000;
      end else if (raw > 12'sh3FF) begin
        code = asc_pkg::SE_MAX;
      end else begin
        code = raw[9:0];
      end
    end
  end

endmodule

// *** verilog/asc_ctrl.sv ***
// Purpose: Register file and conversion sequencer of the converter control block
// Assumes: Trigger sources and core code are synchronous to clk
// Notes:   Read data stands only in the cycle after the read strobe
`timescale 1ns/1ps
module asc_ctrl (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire asc_pkg::asc_bus_t       bus,
  output logic [7:0]                   rdata,
  input  wire logic [7:0]              trig_in,
  input  wire logic                    irq_ack,
  input  wire logic                    global_irq_en,
  output logic                         irq_req,
  input  wire logic signed [11:0]      core_raw,
  output asc_pkg::asc_core_t           core
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]          sel;
    logic                en;
    logic                ate;
    logic                flag;
    logic                ie;
    logic [2:0]          ps;
    logic [2:0]          trig_src;
    asc_pkg::asc_state_t st;
    logic [4:0]          cnt;
    logic [4:0]          len;
    logic                first;
    logic [1:0]          act_ref;
    logic [4:0]          act_ch;
    logic [9:0]          result;
    logic                lock;
    logic                trig_prev;
    logic [7:0]          rdata;
  } asc_ctrl_st_t;

  asc_ctrl_st_t cur_ff;
  asc_ctrl_st_t nxt_st;

  logic       tick;
  logic [9:0] fmt_code;
  logic       wr_ctrl;
  logic       wr_sel;
  logic       wr_trig;
  logic       rd_lo;
  logic       rd_hi;
  logic       trig_lvl;
  logic       trig_edge;
  logic       sw_start;
  logic       done;
  logic       free_run;
  logic       ladj;

  asc_clk_div u_div (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .run     (cur_ff.en),
    .div_sel (cur_ff.ps),
    .tick    (tick)
  );

  asc_code_fmt u_fmt (
    .raw  (core_raw),
    .diff (asc_pkg::asc_is_diff(cur_ff.act_ch)),
    .code (fmt_code)
  );

  // ----------------------------------------------------------------
  // Read helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] res_byte(input logic [9:0] r, input logic left, input logic hi);
    logic [7:0] b;
    b = 8'h00;
    if (left) begin
      b = hi ? r[9:2] : {r[1:0], 6'h00};
    end else begin
      b = hi ? {6'h00, r[9:8]} : r[7:0];
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl = bus.wr && (bus.addr == asc_pkg::OFS_CTRL);
    wr_sel  = bus.wr && (bus.addr == asc_pkg::OFS_SEL);
    wr_trig = bus.wr && (bus.addr == asc_pkg::OFS_CTRL_B);
    rd_lo   = bus.rd && (bus.addr == asc_pkg::OFS_RES_LO);
    rd_hi   = bus.rd && (bus.addr == asc_pkg::OFS_RES_HI);
    ladj    = cur_ff.sel[asc_pkg::SEL_LADJ];
    free_run = cur_ff.ate && (cur_ff.trig_src == asc_pkg::TRIG_FREE);
    // Free running feeds no level, so leaving it never hides an edge and entering it makes none
    trig_lvl = (cur_ff.trig_src == asc_pkg::TRIG_FREE) ? 1'b0 : trig_in[cur_ff.trig_src];
    trig_edge = cur_ff.ate && trig_lvl && !cur_ff.trig_prev;
    sw_start = wr_ctrl && bus.wdata[asc_pkg::CS_START];
    done = (cur_ff.st == asc_pkg::ASC_CONV) && tick && (cur_ff.cnt == cur_ff.len - 5'h01);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic en_next;
    logic start;
    en_next = cur_ff.en;
    start = 1'b0;
    nxt_st = cur_ff;
    nxt_st.trig_prev = trig_lvl;

    // Register writes
    if (wr_sel) begin
      nxt_st.sel = bus.wdata;
    end
    if (wr_trig) begin
      nxt_st.trig_src = bus.wdata[2:0];
    end
    if (wr_ctrl) begin
      en_next = bus.wdata[asc_pkg::CS_EN];
      nxt_st.en  = en_next;
      nxt_st.ate = bus.wdata[asc_pkg::CS_ATE];
      nxt_st.ie  = bus.wdata[asc_pkg::CS_IE];
      nxt_st.ps  = bus.wdata[2:0];
    end

    // Flag clear by write-one or acknowledge; a same-cycle completion wins below
    if ((wr_ctrl && bus.wdata[asc_pkg::CS_FLAG]) || irq_ack) begin
      nxt_st.flag = 1'b0;
    end

    // Sequencer
    unique case (cur_ff.st)
      asc_pkg::ASC_IDLE: begin
        start = en_next && (sw_start || trig_edge);
      end
      asc_pkg::ASC_CONV: begin
        if (tick) begin
          nxt_st.cnt = cur_ff.cnt + 5'h01;
        end
        if (done) begin
          nxt_st.st = asc_pkg::ASC_IDLE;
          nxt_st.flag = 1'b1;
          // A pending low-byte read holds the pair; this result is dropped
          if (!cur_ff.lock) begin
            nxt_st.result = fmt_code;
          end
          start = en_next && (free_run || trig_edge);
        end
      end
    endcase

    if (start) begin
      nxt_st.st = asc_pkg::ASC_CONV;
      nxt_st.cnt = 5'h00;
      nxt_st.len = cur_ff.first ? asc_pkg::LEN_FIRST : asc_pkg::LEN_NORMAL;
      nxt_st.first = 1'b0;
      // Selection is latched here so later writes wait for the next conversion
      nxt_st.act_ref = wr_sel ? bus.wdata[7:6] : cur_ff.sel[7:6];
      nxt_st.act_ch  = wr_sel ? bus.wdata[4:0] : cur_ff.sel[4:0];
    end

    if (!en_next) begin
      nxt_st.st = asc_pkg::ASC_IDLE;
      nxt_st.cnt = 5'h00;
      nxt_st.first = 1'b1;
    end

    // Result pair lock
    if (rd_lo) begin
      nxt_st.lock = 1'b1;
    end else if (rd_hi) begin
      nxt_st.lock = 1'b0;
    end

    // Read data, one cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        asc_pkg::OFS_RES_LO: nxt_st.rdata = res_byte(cur_ff.result, ladj, 1'b0);
        asc_pkg::OFS_RES_HI: nxt_st.rdata = res_byte(cur_ff.result, ladj, 1'b1);
        asc_pkg::OFS_CTRL: begin
          nxt_st.rdata = {cur_ff.en, cur_ff.st == asc_pkg::ASC_CONV, cur_ff.ate,
                          cur_ff.flag, cur_ff.ie, cur_ff.ps};
        end
        asc_pkg::OFS_CTRL_B: nxt_st.rdata = {5'h00, cur_ff.trig_src};
        asc_pkg::OFS_SEL: nxt_st.rdata = cur_ff.sel;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.sel <= asc_pkg::RST_SEL;
      cur_ff.trig_src <= asc_pkg::RST_TRIG;
      cur_ff.first <= 1'b1;
      cur_ff.len <= asc_pkg::LEN_FIRST;
      cur_ff.st <= asc_pkg::ASC_IDLE;
    end else if (ce) begin
      cur_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata   = cur_ff.rdata;
  assign irq_req = cur_ff.flag && cur_ff.ie && global_irq_en;

  always_comb begin
    core.power            = cur_ff.en;
    core.busy             = cur_ff.st == asc_pkg::ASC_CONV;
    core.reference_select = cur_ff.act_ref;
    core.channel_select   = cur_ff.act_ch;
    core.sample           = done;
  end

endmodule

// *** test/asc_core_model.sv ***
// Purpose: Behavioural converter core answering with a raw code
// Assumes: val is the analog level the bench wants converted
// Notes:   Off-conversion output churns so stale codes never match
`timescale 1ns/1ps
module asc_core_model (
  input  wire logic               clk,
  input  wire asc_pkg::asc_core_t core,
  input  wire logic signed [11:0] val,
  output logic signed [11:0]      core_raw
);
  logic alt_ff = 1'b0;
  always @(posedge clk) begin
    alt_ff <= ~alt_ff;
  end
  // Code only valid while powered and busy
  assign core_raw = (core.busy && core.power) ? val : (val ^ {12{alt_ff}}) ^ 12'hA5A;
endmodule

// *** test/asc_ctrl_assertions.sv ***
// Purpose: Port-level checks of the converter control block
// Assumes: ce held high by the bench
// Notes:   Bound to asc_ctrl
`timescale 1ns/1ps
module asc_chk (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               ce,
  input wire asc_pkg::asc_bus_t  bus,
  input wire logic [7:0]         rdata,
  input wire logic [7:0]         trig_in,
  input wire logic               irq_ack,
  input wire logic               global_irq_en,
  input wire logic               irq_req,
  input wire logic signed [11:0] core_raw,
  input wire asc_pkg::asc_core_t core
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic cw;
  assign cw = bus.wr && bus.addr == asc_pkg::OFS_CTRL;
  property p_rst; $fell(rst) |-> core == '0 && rdata == 8'h00 && !irq_req; endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  property p_start; cw && bus.wdata[7:6] == 2'b11 && !core.busy |=> core.busy && core.power; endproperty
  a_start: assert property (p_start) else $error("start write did not begin");
  property p_abort; cw && !bus.wdata[7] |=> !core.busy && !core.power; endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort");
  property p_hold; $past(core.busy) && core.busy && !$past(core.sample) |->
    $stable(core.channel_select) && $stable(core.reference_select); endproperty
  a_hold: assert property (p_hold) else $error("selection changed mid conversion");
  property p_samp; core.sample |-> core.busy && core.power; endproperty
  a_samp: assert property (p_samp) else $error("sample outside conversion");
  property p_pulse; core.sample |=> !core.sample; endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulses too close");
  property p_gie; !global_irq_en |-> !irq_req; endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_ack; irq_ack && !core.sample |=> !irq_req; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge left request");
  property p_first; cw && bus.wdata[7:6] == 2'b11 && bus.wdata[2:1] == 2'b00 && !core.power
    |-> ##[46:54] core.sample; endproperty
  a_first: assert property (p_first) else $error("first conversion length wrong");
endmodule
bind asc_ctrl asc_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata), .trig_in(trig_in),
  .irq_ack(irq_ack), .global_irq_en(global_irq_en), .irq_req(irq_req), .core_raw(core_raw), .core(core));

// *** test/adc_sequencer_control_tb.sv ***
// Purpose: Self-checking bench for the converter control block
// Assumes: 4 ns clock, ce tied high
// Notes:   Read results are queued and checked by a monitor
`timescale 1ns/1ps
module adc_sequencer_control_tb;
  logic clk = 1'b0, rst = 1'b1, ack = 1'b0, gie = 1'b0, rdv = 1'b0, irq_req;
  asc_pkg::asc_bus_t bus = '0;
  asc_pkg::asc_core_t core;
  logic [7:0] rdata, trig = 8'h00, v;
  logic signed [11:0] raw, val = 12'h000;
  logic [7:0] expq[$];
  int bad_count = 0, tests_run = 0, cyc = 0, n, dv;
  logic [7:0] tsel[8] = '{8'h43, 8'h00, 8'hC7, 8'h10, 8'h1D, 8'h1E, 8'h18, 8'h9F};
  logic [11:0] traw[8] = '{12'h000, 12'hFFB, 12'h7D0, 12'h2BC, 12'hD44, 12'h005, 12'hFA3, 12'h000};
  logic [9:0] texp[8] = '{10'h000, 10'h000, 10'h3FF, 10'h1FF, 10'h200, 10'h005, 10'h3A3, 10'h000};
  asc_ctrl dut (.clk(clk), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata), .trig_in(trig), .irq_ack(ack),
    .global_irq_en(gie), .irq_req(irq_req), .core_raw(raw), .core(core));
  asc_core_model u_core (.clk(clk), .core(core), .val(val), .core_raw(raw));
  initial forever #2 clk = ~clk;
  // ----
  // Monitor and helpers
  // ----
  task report_and_stop;
    $display("checks %0d bad %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    rdv <= bus.rd;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  task cmp(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  always @(negedge clk) if (rdv) cmp(rdata, expq.pop_front());
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
  endtask
  task wsamp;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (core.sample !== 1'b1 && n < 4000);
  endtask
  task conv(input int i);
    logic [2:0] ps;
    ps = 3'(i);
    dv = (ps < 2) ? 2 : (1 << ps);
    wr(8'h7C, tsel[i]);
    val <= traw[i];
    wr(8'h7A, {5'h18, ps});
    rd(8'h7A, {5'h18, ps});
    @(negedge clk) cmp({core.reference_select, 1'b0, core.channel_select}, tsel[i] & 8'hDF);
    wsamp;
    if (i > 0) cmp(8'(n >= 12 * dv - 6 && n <= 13 * dv + 2), 8'h01);
    rd(8'h7A, {5'h12, ps});
    wr(8'h7A, {5'h12, ps});
    rd(8'h7A, {5'h10, ps});
    rd(8'h78, texp[i][7:0]);
    rd(8'h79, {6'h00, texp[i][9:8]});
    wr(8'h7C, tsel[i] | 8'h20);
    rd(8'h78, {texp[i][1:0], 6'h00});
    rd(8'h79, texp[i][9:2]);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(59));
    texp[0] = 10'($urandom % 1024);
    traw[0] = {2'b00, texp[0]};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (tsel[i]) rd(8'h78 + 8'(i % 5), 8'h00);
    rd(8'h70, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      v = {2'(i), 1'($urandom), 5'(i)};
      wr(8'h7C, v);
      rd(8'h7C, v);
    end
    $display("test select done");
    for (int i = 0; i < 8; i++) conv(i);
    $display("test conversions done");
    wr(8'h7A, 8'hC3);
    repeat (10) @(posedge clk);
    wr(8'h7A, 8'h03);
    repeat (120) @(posedge clk);
    rd(8'h7A, 8'h03);
    wr(8'h7A, 8'hC0);
    wsamp;
    cmp(8'(n >= 46 && n <= 54), 8'h01);
    wr(8'h7A, 8'h90);
    $display("test abort done");
    wr(8'h7C, 8'h00);
    val <= 12'h155;
    gie <= 1'b1;
    wr(8'h7A, 8'hC8);
    wsamp;
    @(negedge clk) cmp({7'h00, irq_req}, 8'h01);
    @(posedge clk) gie <= 1'b0;
    @(negedge clk) cmp({7'h00, irq_req}, 8'h00);
    @(posedge clk) gie <= 1'b1;
    @(posedge clk) ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
    @(negedge clk) cmp({7'h00, irq_req}, 8'h00);
    rd(8'h7A, 8'h88);
    rd(8'h78, 8'h55);
    val <= 12'h2AA;
    wr(8'h7A, 8'hC0);
    wsamp;
    wr(8'h7A, 8'h80);
    rd(8'h7A, 8'h90);
    wr(8'h7A, 8'h90);
    rd(8'h79, 8'h01);
    rd(8'h78, 8'h55);
    rd(8'h79, 8'h01);
    $display("test interrupt and lock done");
    wr(8'h7B, 8'h02);
    wr(8'h7A, 8'hA0);
    @(posedge clk) trig <= 8'h04;
    wsamp;
    rd(8'h7A, 8'hB0);
    trig <= 8'h00;
    wr(8'h7B, 8'h00);
    repeat (8) @(posedge clk);
    @(negedge clk) cmp({7'h00, core.busy}, 8'h00);
    wr(8'h7A, 8'hF0);
    wr(8'h7C, 8'h1F);
    @(negedge clk) cmp({3'h0, core.channel_select}, 8'h00);
    wsamp;
    wsamp;
    @(negedge clk) cmp({7'h00, core.busy}, 8'h01);
    cmp({3'h0, core.channel_select}, 8'h1F);
    wr(8'h7A, 8'h00);
    $display("test trigger done");
    report_and_stop;
  end
endmodule
